// ===== hdl/pmbus_command_status_unit.sv
// Command handling, status latching and link crossing of the controller
`timescale 1ns/1ns
module pmbus_command_status_unit #(
	parameter int PG_CYCLES   = pmbus_cmd_pkg::PG_CYC,
	parameter int MS_CYCLES   = pmbus_cmd_pkg::MS_CYC,
	parameter int NVM_CYCLES  = pmbus_cmd_pkg::NVM_CYC,
	parameter bit ON_AT_RESET = 1'b1
) (
	// Core clock and reset
	input  wire logic                      ref_clk_in,
	input  wire logic                      rst_in,
	// Link side, framed by the bus front end
	input  wire logic                      link_clk_in,
	input  wire logic                      lk_cmd_valid_in,
	input  wire logic                      lk_read_in,
	input  wire logic                      lk_byte_valid_in,
	input  wire logic [7:0]                lk_byte_in,
	input  wire logic                      lk_end_in,
	input  wire logic                      lk_rd_ack_in,
	output logic                           lk_busy_out,
	output logic                           lk_rd_valid_out,
	output logic [7:0]                     lk_rd_byte_out,
	// Converter stage
	input  wire logic                      stage_active_in,
	input  wire logic                      hi_supply_ok_in,
	input  wire logic                      stage_talk_in,
	input  wire pmbus_cmd_pkg::stage_evt_t stage_evt_in,
	input  wire logic                      telem_valid_in,
	input  wire pmbus_cmd_pkg::telem_t     telem_in,
	output logic                           stage_enable_out
);
	localparam int PW = $clog2(PG_CYCLES + 1);
	localparam int MW = $clog2(MS_CYCLES + 1);
	localparam int NW = $clog2(NVM_CYCLES + 1);

	// Page access check for one command
	function automatic logic access_ok(input logic [7:0] code,
		input logic [7:0] page, input logic rd);
		logic p1;
		p1 = (page == pmbus_cmd_pkg::PAGE_STAGE);
		case (code)
		pmbus_cmd_pkg::C_PAGE:      access_ok = 1'b1;
		pmbus_cmd_pkg::C_OPERATION: access_ok = rd || p1;
		pmbus_cmd_pkg::C_CLEAR:     access_ok = !rd;
		pmbus_cmd_pkg::C_FEATURE:   access_ok = rd && !p1;
		pmbus_cmd_pkg::C_OT_FAULT, pmbus_cmd_pkg::C_OT_WARN,
		pmbus_cmd_pkg::C_OV_FAULT, pmbus_cmd_pkg::C_OV_WARN,
		pmbus_cmd_pkg::C_OC_FAULT, pmbus_cmd_pkg::C_OC_WARN,
		pmbus_cmd_pkg::C_TON:       access_ok = p1;
		pmbus_cmd_pkg::C_SBYTE:     access_ok = rd || !p1;
		pmbus_cmd_pkg::C_SWORD, pmbus_cmd_pkg::C_HI_I,
		pmbus_cmd_pkg::C_LO_I, pmbus_cmd_pkg::C_TEMP:
			access_ok = rd;
		pmbus_cmd_pkg::C_ST_CUR, pmbus_cmd_pkg::C_ST_IN,
		pmbus_cmd_pkg::C_ST_TEMP, pmbus_cmd_pkg::C_ST_VEND:
			access_ok = rd || p1;
		pmbus_cmd_pkg::C_ST_COMM:   access_ok = !p1;
		pmbus_cmd_pkg::C_HI_V, pmbus_cmd_pkg::C_LO_V:
			access_ok = rd && p1;
		default:                    access_ok = 1'b0;
		endcase
	endfunction

	// Data bytes a write carries
	function automatic logic [1:0] cmd_len(input logic [7:0] code);
		case (code)
		pmbus_cmd_pkg::C_CLEAR:     cmd_len = 2'd0;
		pmbus_cmd_pkg::C_OT_FAULT, pmbus_cmd_pkg::C_OT_WARN,
		pmbus_cmd_pkg::C_OV_FAULT, pmbus_cmd_pkg::C_OV_WARN,
		pmbus_cmd_pkg::C_OC_FAULT, pmbus_cmd_pkg::C_OC_WARN,
		pmbus_cmd_pkg::C_TON:       cmd_len = 2'd2;
		default:                    cmd_len = 2'd1;
		endcase
	endfunction

	// Limit slot of a code, LIM_NUM when none
	function automatic logic [2:0] lim_index(input logic [7:0] code);
		case (code)
		pmbus_cmd_pkg::C_OT_FAULT: lim_index = 3'd0;
		pmbus_cmd_pkg::C_OT_WARN:  lim_index = 3'd1;
		pmbus_cmd_pkg::C_OV_FAULT: lim_index = 3'd2;
		pmbus_cmd_pkg::C_OV_WARN:  lim_index = 3'd3;
		pmbus_cmd_pkg::C_OC_FAULT: lim_index = 3'd4;
		pmbus_cmd_pkg::C_OC_WARN:  lim_index = 3'd5;
		default: lim_index = 3'(pmbus_cmd_pkg::LIM_NUM);
		endcase
	endfunction

	// Status slot of a code, ST_NUM when none
	function automatic logic [2:0] st_index(input logic [7:0] code);
		case (code)
		pmbus_cmd_pkg::C_ST_CUR:  st_index = 3'(pmbus_cmd_pkg::ST_CUR);
		pmbus_cmd_pkg::C_ST_IN:   st_index = 3'(pmbus_cmd_pkg::ST_IN);
		pmbus_cmd_pkg::C_ST_TEMP: st_index = 3'(pmbus_cmd_pkg::ST_TEMP);
		pmbus_cmd_pkg::C_ST_COMM: st_index = 3'(pmbus_cmd_pkg::ST_COMM);
		pmbus_cmd_pkg::C_ST_VEND: st_index = 3'(pmbus_cmd_pkg::ST_VEND);
		default: st_index = 3'(pmbus_cmd_pkg::ST_NUM);
		endcase
	endfunction

	// Link domain state
	logic                lk_rst_meta_ff;
	logic                lk_rst_ff;
	pmbus_cmd_pkg::req_t lk_req_ff;
	logic                lk_open_ff;
	logic                lk_pend_ff;
	logic                lk_req_tgl_ff;
	logic                lk_ack_meta_ff;
	logic                lk_ack_sync_ff;
	logic                lk_ack_prev_ff;
	logic [15:0]         lk_word_ff;
	logic                lk_hi_ff;
	logic                lk_rdv_ff;
	logic [7:0]          lk_rbyte_ff;
	logic                lk_ack_evt;
	logic                lk_launch;
	logic                lk_new_cmd;

	// Core domain state
	logic                rq_meta_ff;
	logic                rq_sync_ff;
	logic                rq_prev_ff;
	logic                rq_evt;
	logic                ack_tgl_ff;
	logic [15:0]         rsp_word_ff;
	logic [7:0]          page_ff;
	logic                op_on_ff;
	logic [7:0]          lim_ff [pmbus_cmd_pkg::LIM_NUM];
	logic [15:0]         ton_ff;
	logic                busy_ff;
	logic [7:0]          st_ff [pmbus_cmd_pkg::ST_NUM];
	logic                seen_ff;
	logic                en_ff;
	logic [MW-1:0]       ms_cnt_ff;
	logic [6:0]          ton_left_ff;
	logic [PW-1:0]       pg_cnt_ff;
	logic [NW-1:0]       nvm_cnt_ff;
	pmbus_cmd_pkg::telem_t telem_ff;

	// Decode results
	pmbus_cmd_pkg::req_t rq;
	logic [15:0]         nxt_rsp_word;
	logic [7:0]          cml_set;
	logic                wr_page, wr_op, wr_lim, wr_ton;
	logic                do_clear, busy_set, busy_clr;
	logic [7:0]          w1c [pmbus_cmd_pkg::ST_NUM];
	logic [7:0]          st_set [pmbus_cmd_pkg::ST_NUM];
	logic [7:0]          st_clr [pmbus_cmd_pkg::ST_NUM];
	logic                disabled, pg_n, link_fault, nota;
	logic [7:0]          sbyte;
	logic [15:0]         sword;

	// Reset brought into the link domain
	always_ff @(posedge link_clk_in) begin
		lk_rst_meta_ff <= rst_in;
		lk_rst_ff      <= lk_rst_meta_ff;
	end

	assign lk_new_cmd = lk_cmd_valid_in && !lk_pend_ff;
	assign lk_launch  = (lk_new_cmd && lk_read_in) || (lk_open_ff && lk_end_in);
	assign lk_ack_evt = lk_ack_sync_ff ^ lk_ack_prev_ff;

	// Message assembly from framed bytes
	always_ff @(posedge link_clk_in) begin
		if (lk_rst_ff) begin
			lk_req_ff  <= '0;
			lk_open_ff <= 1'b0;
		end else if (lk_new_cmd) begin
			lk_req_ff.is_read <= lk_read_in;
			lk_req_ff.code    <= lk_byte_in;
			lk_req_ff.data    <= 16'h0000;
			lk_req_ff.nbytes  <= 2'd0;
			lk_open_ff        <= !lk_read_in;
		end else if (lk_open_ff && lk_end_in) begin
			lk_open_ff <= 1'b0;
		end else if (lk_open_ff && lk_byte_valid_in) begin
			case (lk_req_ff.nbytes)
			2'd0: lk_req_ff.data[7:0]  <= lk_byte_in;
			2'd1: lk_req_ff.data[15:8] <= lk_byte_in;
			default: ;
			endcase
			if (lk_req_ff.nbytes != 2'd3) begin
				lk_req_ff.nbytes <= lk_req_ff.nbytes + 2'd1;
			end
		end
	end

	// Request toggle out, answer toggle back
	always_ff @(posedge link_clk_in) begin
		if (lk_rst_ff) begin
			lk_req_tgl_ff  <= 1'b0;
			lk_pend_ff     <= 1'b0;
			lk_ack_meta_ff <= 1'b0;
			lk_ack_sync_ff <= 1'b0;
			lk_ack_prev_ff <= 1'b0;
		end else begin
			lk_ack_meta_ff <= ack_tgl_ff;
			lk_ack_sync_ff <= lk_ack_meta_ff;
			lk_ack_prev_ff <= lk_ack_sync_ff;
			if (lk_launch) begin
				lk_req_tgl_ff <= !lk_req_tgl_ff;
				lk_pend_ff    <= 1'b1;
			end else if (lk_ack_evt) begin
				lk_pend_ff <= 1'b0;
			end
		end
	end

	// Read bytes handed out low first
	always_ff @(posedge link_clk_in) begin
		if (lk_rst_ff || lk_new_cmd) begin
			lk_rdv_ff   <= 1'b0;
			lk_hi_ff    <= 1'b0;
			lk_rbyte_ff <= 8'hff;
			lk_word_ff  <= 16'hffff;
		end else if (lk_ack_evt && lk_req_ff.is_read) begin
			lk_rdv_ff   <= 1'b1;
			lk_word_ff  <= rsp_word_ff;
			lk_rbyte_ff <= rsp_word_ff[7:0];
		end else if (lk_rdv_ff && lk_rd_ack_in) begin
			lk_hi_ff    <= 1'b1;
			lk_rbyte_ff <= lk_hi_ff ? 8'hff : lk_word_ff[15:8];
		end
	end

	assign lk_busy_out     = lk_pend_ff;
	assign lk_rd_valid_out = lk_rdv_ff;
	assign lk_rd_byte_out  = lk_rbyte_ff;

	// Request toggle into the core domain
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			rq_meta_ff <= 1'b0;
			rq_sync_ff <= 1'b0;
			rq_prev_ff <= 1'b0;
		end else begin
			rq_meta_ff <= lk_req_tgl_ff;
			rq_sync_ff <= rq_meta_ff;
			rq_prev_ff <= rq_sync_ff;
		end
	end

	assign rq_evt   = rq_sync_ff ^ rq_prev_ff;
	assign rq       = lk_req_ff;
	assign disabled = !en_ff && !stage_active_in;

	// Summary byte and word from latched flags, stage activity and power good
	always_comb begin
		sbyte = 8'h00;
		sword = 16'h0000;
		sword[pmbus_cmd_pkg::SW_CUR]  = |st_ff[pmbus_cmd_pkg::ST_CUR];
		sword[pmbus_cmd_pkg::SW_IN]   = |st_ff[pmbus_cmd_pkg::ST_IN];
		sword[pmbus_cmd_pkg::SW_VEND] = |st_ff[pmbus_cmd_pkg::ST_VEND];
		sword[pmbus_cmd_pkg::SW_PG_N] = pg_n;
		nota = |st_ff[pmbus_cmd_pkg::ST_VEND] || |sword[15:8];
		sbyte[pmbus_cmd_pkg::SB_BUSY]   = busy_ff;
		sbyte[pmbus_cmd_pkg::SB_OFF]    = !stage_active_in;
		sbyte[pmbus_cmd_pkg::SB_CUR_OC] =
			st_ff[pmbus_cmd_pkg::ST_CUR][pmbus_cmd_pkg::CUR_OC_FAULT];
		sbyte[pmbus_cmd_pkg::SB_IN_UV]  =
			st_ff[pmbus_cmd_pkg::ST_IN][pmbus_cmd_pkg::IN_UV_FAULT];
		sbyte[pmbus_cmd_pkg::SB_TEMP]   = |st_ff[pmbus_cmd_pkg::ST_TEMP];
		sbyte[pmbus_cmd_pkg::SB_COMM]   = |st_ff[pmbus_cmd_pkg::ST_COMM];
		sbyte[pmbus_cmd_pkg::SB_NOTA]   = nota;
		sword[7:0] = sbyte;
	end

	// Command decode and read answer
	always_comb begin
		nxt_rsp_word = 16'hffff;
		cml_set  = 8'h00;
		wr_page  = 1'b0;
		wr_op    = 1'b0;
		wr_lim   = 1'b0;
		wr_ton   = 1'b0;
		do_clear = 1'b0;
		busy_set = 1'b0;
		busy_clr = 1'b0;
		for (int i = 0; i < pmbus_cmd_pkg::ST_NUM; i++) begin
			w1c[i] = 8'h00;
		end
		if (!rq_evt) begin
			nxt_rsp_word = rsp_word_ff;
		end else if (nvm_cnt_ff != '0) begin
			busy_set = 1'b1;
		end else if (!access_ok(rq.code, page_ff, rq.is_read)) begin
			cml_set[pmbus_cmd_pkg::CML_BAD_CMD] = 1'b1;
		end else if (rq.is_read) begin
			case (rq.code)
			pmbus_cmd_pkg::C_PAGE:    nxt_rsp_word = {8'h00, page_ff};
			pmbus_cmd_pkg::C_OPERATION:
				nxt_rsp_word = {8'h00, op_on_ff ? pmbus_cmd_pkg::OP_ON
					: pmbus_cmd_pkg::OP_OFF};
			pmbus_cmd_pkg::C_FEATURE:
				nxt_rsp_word = {8'h00, pmbus_cmd_pkg::FEATURE_VAL};
			pmbus_cmd_pkg::C_TON:     nxt_rsp_word = ton_ff;
			pmbus_cmd_pkg::C_SBYTE:   nxt_rsp_word = {8'h00, sbyte};
			pmbus_cmd_pkg::C_SWORD:   nxt_rsp_word = sword;
			pmbus_cmd_pkg::C_HI_V:    nxt_rsp_word = telem_ff.hi_v;
			pmbus_cmd_pkg::C_HI_I:    nxt_rsp_word = telem_ff.hi_i;
			pmbus_cmd_pkg::C_LO_V:    nxt_rsp_word = telem_ff.lo_v;
			pmbus_cmd_pkg::C_LO_I:    nxt_rsp_word = telem_ff.lo_i;
			pmbus_cmd_pkg::C_TEMP:    nxt_rsp_word = telem_ff.temp;
			default: begin
				if (lim_index(rq.code) != 3'(pmbus_cmd_pkg::LIM_NUM)) begin
					nxt_rsp_word = {8'h00, lim_ff[lim_index(rq.code)]};
				end else begin
					nxt_rsp_word = {8'h00, st_ff[st_index(rq.code)]};
				end
			end
			endcase
		end else if (rq.nbytes != cmd_len(rq.code)) begin
			cml_set[pmbus_cmd_pkg::CML_OTHER] = 1'b1;
		end else begin
			case (rq.code)
			pmbus_cmd_pkg::C_PAGE: begin
				if (rq.data[7:0] == pmbus_cmd_pkg::PAGE_CTRL ||
					rq.data[7:0] == pmbus_cmd_pkg::PAGE_STAGE) begin
					wr_page = 1'b1;
				end else begin
					cml_set[pmbus_cmd_pkg::CML_BAD_DATA] = 1'b1;
				end
			end
			pmbus_cmd_pkg::C_OPERATION: begin
				if (rq.data[7:0] == pmbus_cmd_pkg::OP_ON ||
					rq.data[7:0] == pmbus_cmd_pkg::OP_OFF) begin
					wr_op = 1'b1;
				end else begin
					cml_set[pmbus_cmd_pkg::CML_BAD_DATA] = 1'b1;
				end
			end
			pmbus_cmd_pkg::C_CLEAR: do_clear = 1'b1;
			pmbus_cmd_pkg::C_SBYTE: begin
				busy_clr = page_ff == pmbus_cmd_pkg::PAGE_CTRL &&
					(rq.data[7:0] == pmbus_cmd_pkg::BUSY_CLR_A ||
					rq.data[7:0] == pmbus_cmd_pkg::BUSY_CLR_B);
			end
			pmbus_cmd_pkg::C_TON: begin
				if (!disabled) begin
					cml_set[pmbus_cmd_pkg::CML_OTHER] = 1'b1;
				end else if (rq.data > pmbus_cmd_pkg::TON_MAX) begin
					cml_set[pmbus_cmd_pkg::CML_BAD_DATA] = 1'b1;
				end else begin
					wr_ton = 1'b1;
				end
			end
			default: begin
				if (st_index(rq.code) != 3'(pmbus_cmd_pkg::ST_NUM)) begin
					w1c[st_index(rq.code)] = rq.data[7:0];
				end else if (!disabled) begin
					cml_set[pmbus_cmd_pkg::CML_OTHER] = 1'b1;
				end else if (rq.data > pmbus_cmd_pkg::PCT_MAX) begin
					cml_set[pmbus_cmd_pkg::CML_BAD_DATA] = 1'b1;
				end else begin
					wr_lim = 1'b1;
				end
			end
			endcase
		end
	end

	// Answer word and answer toggle
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			rsp_word_ff <= 16'hffff;
			ack_tgl_ff  <= 1'b0;
		end else begin
			rsp_word_ff <= nxt_rsp_word;
			if (rq_evt) begin
				ack_tgl_ff <= !ack_tgl_ff;
			end
		end
	end

	// Page and on/off request
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			page_ff  <= pmbus_cmd_pkg::PAGE_CTRL;
			op_on_ff <= ON_AT_RESET;
		end else begin
			if (wr_page) begin
				page_ff <= rq.data[7:0];
			end
			if (wr_op) begin
				op_on_ff <= rq.data[7:0] == pmbus_cmd_pkg::OP_ON;
			end
		end
	end

	// Limit and delay storage, kept across stage shutdowns
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			for (int i = 0; i < pmbus_cmd_pkg::LIM_NUM; i++) begin
				lim_ff[i] <= pmbus_cmd_pkg::PCT_MAX[7:0];
			end
			ton_ff <= pmbus_cmd_pkg::TON_RESET;
		end else begin
			if (wr_lim) begin
				lim_ff[lim_index(rq.code)] <= rq.data[7:0];
			end
			if (wr_ton) begin
				ton_ff <= rq.data;
			end
		end
	end

	// Storage write time, requests refused meanwhile
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			nvm_cnt_ff <= '0;
		end else if (wr_lim || wr_ton) begin
			nvm_cnt_ff <= NW'(NVM_CYCLES);
		end else if (nvm_cnt_ff != '0) begin
			nvm_cnt_ff <= nvm_cnt_ff - 1'b1;
		end
	end

	// Busy flag, set wins over clear
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			busy_ff <= 1'b0;
		end else if (busy_set) begin
			busy_ff <= 1'b1;
		end else if (busy_clr || do_clear) begin
			busy_ff <= 1'b0;
		end
	end

	// Link silence after first contact
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			seen_ff <= 1'b0;
		end else if (stage_talk_in) begin
			seen_ff <= 1'b1;
		end
	end

	assign link_fault = seen_ff && stage_active_in && !stage_talk_in;

	// Set and clear terms per status register
	always_comb begin
		st_set[pmbus_cmd_pkg::ST_CUR]  = stage_evt_in.cur;
		st_set[pmbus_cmd_pkg::ST_IN]   = stage_evt_in.supply;
		st_set[pmbus_cmd_pkg::ST_IN][pmbus_cmd_pkg::IN_UV_FAULT] =
			stage_evt_in.supply[pmbus_cmd_pkg::IN_UV_FAULT] ||
			!hi_supply_ok_in;
		st_set[pmbus_cmd_pkg::ST_TEMP] = stage_evt_in.temp;
		st_set[pmbus_cmd_pkg::ST_COMM] = cml_set;
		st_set[pmbus_cmd_pkg::ST_VEND] = 8'h00;
		st_set[pmbus_cmd_pkg::ST_VEND][pmbus_cmd_pkg::VEND_REVERSE] =
			stage_evt_in.reverse;
		st_set[pmbus_cmd_pkg::ST_VEND][pmbus_cmd_pkg::VEND_HW_PROT] =
			stage_evt_in.hw_trip || stage_evt_in.dis_evt;
		st_set[pmbus_cmd_pkg::ST_VEND][pmbus_cmd_pkg::VEND_LINK] =
			link_fault;
		for (int i = 0; i < pmbus_cmd_pkg::ST_NUM; i++) begin
			st_clr[i] = w1c[i] | {8{do_clear}};
		end
		st_clr[pmbus_cmd_pkg::ST_VEND][pmbus_cmd_pkg::VEND_LINK] =
			w1c[pmbus_cmd_pkg::ST_VEND][pmbus_cmd_pkg::VEND_LINK] ||
			(do_clear && page_ff == pmbus_cmd_pkg::PAGE_CTRL);
	end

	// Latched status flags, set wins so active faults reassert
	for (genvar g = 0; g < pmbus_cmd_pkg::ST_NUM; g++) begin : g_st
		always_ff @(posedge ref_clk_in) begin
			if (rst_in) begin
				st_ff[g] <= 8'h00;
			end else begin
				st_ff[g] <= (st_ff[g] & ~st_clr[g]) | st_set[g];
			end
		end
	end

	// Turn-on delay ahead of the stage's own startup
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || !op_on_ff) begin
			en_ff       <= 1'b0;
			ms_cnt_ff   <= '0;
			ton_left_ff <= ton_ff[6:0];
		end else if (!en_ff) begin
			if (ton_left_ff == 7'd0) begin
				en_ff <= 1'b1;
			end else if (ms_cnt_ff == MW'(MS_CYCLES - 1)) begin
				ms_cnt_ff   <= '0;
				ton_left_ff <= ton_left_ff - 7'd1;
			end else begin
				ms_cnt_ff <= ms_cnt_ff + 1'b1;
			end
		end
	end

	// Stage restarts on its own after a fault while enable holds
	assign stage_enable_out = en_ff;

	// Soft-start wait before power good
	always_ff @(posedge ref_clk_in) begin
		if (rst_in || !stage_active_in) begin
			pg_cnt_ff <= '0;
		end else if (pg_cnt_ff != PW'(PG_CYCLES)) begin
			pg_cnt_ff <= pg_cnt_ff + 1'b1;
		end
	end

	assign pg_n = pg_cnt_ff != PW'(PG_CYCLES);

	// Last telemetry, frozen while high-side supply is lost
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			telem_ff <= '1;
		end else if (telem_valid_in && hi_supply_ok_in) begin
			telem_ff <= telem_in;
		end
	end
endmodule

// ===== hdl/pmbus_cmd_pkg.sv
// Constants and carrier types for the management command unit
package pmbus_cmd_pkg;
	// Command codes
	localparam logic [7:0] C_PAGE     = 8'h00;
	localparam logic [7:0] C_OPERATION = 8'h01;
	localparam logic [7:0] C_CLEAR    = 8'h03;
	localparam logic [7:0] C_FEATURE  = 8'h19;
	localparam logic [7:0] C_OT_FAULT = 8'h4f;
	localparam logic [7:0] C_OT_WARN  = 8'h51;
	localparam logic [7:0] C_OV_FAULT = 8'h55;
	localparam logic [7:0] C_OV_WARN  = 8'h57;
	localparam logic [7:0] C_OC_FAULT = 8'h5b;
	localparam logic [7:0] C_OC_WARN  = 8'h5d;
	localparam logic [7:0] C_TON      = 8'h60;
	localparam logic [7:0] C_SBYTE    = 8'h78;
	localparam logic [7:0] C_SWORD    = 8'h79;
	localparam logic [7:0] C_ST_CUR   = 8'h7b;
	localparam logic [7:0] C_ST_IN    = 8'h7c;
	localparam logic [7:0] C_ST_TEMP  = 8'h7d;
	localparam logic [7:0] C_ST_COMM  = 8'h7e;
	localparam logic [7:0] C_ST_VEND  = 8'h80;
	localparam logic [7:0] C_HI_V     = 8'h88;
	localparam logic [7:0] C_HI_I     = 8'h89;
	localparam logic [7:0] C_LO_V     = 8'h8b;
	localparam logic [7:0] C_LO_I     = 8'h8c;
	localparam logic [7:0] C_TEMP     = 8'h8d;
	// Data values and reset values
	localparam logic [7:0]  PAGE_CTRL   = 8'h00;
	localparam logic [7:0]  PAGE_STAGE  = 8'h01;
	localparam logic [7:0]  OP_OFF      = 8'h00;
	localparam logic [7:0]  OP_ON       = 8'h80;
	localparam logic [7:0]  FEATURE_VAL = 8'h20;
	localparam logic [15:0] PCT_MAX     = 16'h0064;
	localparam logic [15:0] TON_MAX     = 16'h0064;
	localparam logic [15:0] TON_RESET   = 16'h0000;
	localparam logic [7:0]  BUSY_CLR_A  = 8'h40;
	localparam logic [7:0]  BUSY_CLR_B  = 8'h80;
	// Status array slots and index meaning none
	localparam int ST_CUR = 0, ST_IN = 1, ST_TEMP = 2, ST_COMM = 3;
	localparam int ST_VEND = 4, ST_NUM = 5, LIM_NUM = 6;
	// Bit positions
	localparam int SB_BUSY = 7, SB_OFF = 6, SB_CUR_OC = 4, SB_IN_UV = 3;
	localparam int SB_TEMP = 2, SB_COMM = 1, SB_NOTA = 0;
	localparam int SW_CUR = 14, SW_IN = 13, SW_VEND = 12, SW_PG_N = 11;
	localparam int CML_BAD_CMD = 7, CML_BAD_DATA = 6, CML_OTHER = 1;
	localparam int CUR_OC_FAULT = 7, IN_UV_FAULT = 4;
	localparam int VEND_REVERSE = 0, VEND_HW_PROT = 1, VEND_LINK = 2;
	// Timing
	localparam int CLK_HZ     = 100_000_000;
	localparam int PG_TIME_US = 5000;
	localparam int MS_CYC     = CLK_HZ / 1000;
	localparam int PG_CYC     = PG_TIME_US * (CLK_HZ / 1_000_000);
	localparam int NVM_MS     = 200;
	localparam int NVM_CYC    = NVM_MS * MS_CYC;
	// Carriers
	typedef struct packed {
		logic        is_read;
		logic [7:0]  code;
		logic [15:0] data;
		logic [1:0]  nbytes;
	} req_t;
	typedef struct packed {
		logic [7:0] cur;
		logic [7:0] supply;
		logic [7:0] temp;
		logic       reverse;
		logic       hw_trip;
		logic       dis_evt;
	} stage_evt_t;
	typedef struct packed {
		logic [15:0] hi_v;
		logic [15:0] hi_i;
		logic [15:0] lo_v;
		logic [15:0] lo_i;
		logic [15:0] temp;
	} telem_t;
endpackage

// ===== bench/pmbus_unit_chk.sv
// Port checker for the command status unit
`timescale 1ns/1ns
module pmbus_unit_chk (
	// Watched ports
	input wire logic       ref_clk_in, rst_in, link_clk_in, lk_read_in,
	input wire logic       lk_cmd_valid_in, lk_end_in, lk_rd_ack_in,
	input wire logic       lk_busy_out, lk_rd_valid_out, stage_enable_out,
	input wire logic [7:0] lk_rd_byte_out
);
	rdv_busy_a: assert property (
		@(posedge link_clk_in) disable iff (rst_in)
		$rose(lk_rd_valid_out) |-> $fell(lk_busy_out)) else $error("rdv");
	busy_end_a: assert property (
		@(posedge link_clk_in) disable iff (rst_in)
		$rose(lk_busy_out) |-> ##[1:12] !lk_busy_out) else $error("busy");
	read_go_a: assert property (
		@(posedge link_clk_in) disable iff (rst_in)
		lk_cmd_valid_in && lk_read_in && !lk_busy_out |=> lk_busy_out)
		else $error("read go");
	write_go_a: assert property (
		@(posedge link_clk_in) disable iff (rst_in)
		lk_end_in && !lk_busy_out |=> lk_busy_out) else $error("wr go");
	rdv_drop_a: assert property (
		@(posedge link_clk_in) disable iff (rst_in)
		lk_cmd_valid_in && !lk_busy_out |=> !lk_rd_valid_out)
		else $error("rdv drop");
	byte_hold_a: assert property (
		@(posedge link_clk_in) disable iff (rst_in)
		lk_rd_valid_out && !lk_rd_ack_in && !lk_cmd_valid_in
		|=> $stable(lk_rd_byte_out)) else $error("byte hold");
	en_reset_a: assert property (@(posedge ref_clk_in)
		rst_in |=> !stage_enable_out) else $error("en reset");
	en_boot_a: assert property (@(posedge ref_clk_in)
		$fell(rst_in) |-> ##[1:3] stage_enable_out) else $error("en boot");
endmodule
bind pmbus_command_status_unit pmbus_unit_chk u_chk (.ref_clk_in, .rst_in,
	.link_clk_in, .lk_read_in, .lk_cmd_valid_in, .lk_end_in, .lk_rd_ack_in,
	.lk_busy_out, .lk_rd_valid_out, .stage_enable_out, .lk_rd_byte_out);

// ===== bench/mgmt_host_model.sv
// Host model framing link messages
`timescale 1ns/1ns
module mgmt_host_model (
	// Answers
	input wire logic       link_clk_in, lk_busy_out, lk_rd_valid_out,
	input wire logic [7:0] lk_rd_byte_out,
	// Requests
	output logic       lk_cmd_valid_in, lk_read_in, lk_byte_valid_in,
	output logic       lk_end_in, lk_rd_ack_in,
	output logic [7:0] lk_byte_in
);
	initial begin
		{lk_cmd_valid_in, lk_read_in, lk_byte_valid_in} = 3'h0;
		{lk_end_in, lk_rd_ack_in, lk_byte_in} = 10'h000;
	end
	// Write, low byte first, then storage wait
	task automatic wr(input logic [7:0] c, input logic [15:0] d, int n);
		@(posedge link_clk_in);
		{lk_cmd_valid_in, lk_read_in, lk_byte_in} <= {2'b10, c};
		for (int i = 0; i < n; i++) begin
			@(posedge link_clk_in);
			lk_cmd_valid_in <= 1'b0;
			{lk_byte_valid_in, lk_byte_in} <= {1'b1, d[8*i +: 8]};
		end
		@(posedge link_clk_in);
		{lk_cmd_valid_in, lk_byte_valid_in, lk_end_in} <= 3'b001;
		lk_byte_in <= ~lk_byte_in;
		@(posedge link_clk_in);
		lk_end_in <= 1'b0;
		repeat (16) @(posedge link_clk_in);
	endtask
	// Read, low byte then high byte
	task automatic rd(input logic [7:0] c, output logic [15:0] v);
		@(posedge link_clk_in);
		{lk_cmd_valid_in, lk_read_in, lk_byte_in} <= {2'b11, c};
		@(posedge link_clk_in);
		{lk_cmd_valid_in, lk_byte_in} <= {1'b0, ~c};
		// Let the stale valid of the last read drop first
		#1;
		for (int k = 0; k < 40 && lk_rd_valid_out !== 1'b1; k++) begin
			@(posedge link_clk_in);
			#1;
		end
		v[7:0] = lk_rd_byte_out;
		@(posedge link_clk_in);
		lk_rd_ack_in <= 1'b1;
		@(posedge link_clk_in);
		lk_rd_ack_in <= 1'b0;
		@(posedge link_clk_in);
		#1;
		v[15:8] = lk_rd_byte_out;
	endtask
endmodule

// ===== bench/pmbus_command_status_unit_bench.sv
// Self-checking bench for the command status unit
`timescale 1ns/1ns
module pmbus_command_status_unit_bench;
	logic ref_clk_in, link_clk_in, rst_in, lk_cmd_valid_in, lk_read_in;
	logic lk_byte_valid_in, lk_end_in, lk_rd_ack_in, lk_busy_out;
	logic lk_rd_valid_out, stage_active_in, hi_supply_ok_in, stage_talk_in;
	logic telem_valid_in, stage_enable_out;
	logic [7:0] lk_byte_in, lk_rd_byte_out;
	logic [15:0] v;
	pmbus_cmd_pkg::stage_evt_t stage_evt_in;
	pmbus_cmd_pkg::telem_t telem_in;
	int num_errors = 0;
	int check_count = 0;
	pmbus_command_status_unit #(.PG_CYCLES(50), .MS_CYCLES(10),
		.NVM_CYCLES(20)) u_dut (.ref_clk_in, .rst_in, .link_clk_in,
		.lk_cmd_valid_in, .lk_read_in, .lk_byte_valid_in, .lk_byte_in,
		.lk_end_in, .lk_rd_ack_in, .lk_busy_out, .lk_rd_valid_out,
		.lk_rd_byte_out, .stage_active_in, .hi_supply_ok_in, .stage_talk_in,
		.stage_evt_in, .telem_valid_in, .telem_in, .stage_enable_out);
	mgmt_host_model u_host (.link_clk_in, .lk_busy_out, .lk_rd_valid_out,
		.lk_rd_byte_out, .lk_cmd_valid_in, .lk_read_in, .lk_byte_valid_in,
		.lk_end_in, .lk_rd_ack_in, .lk_byte_in);
	// Clocks and a stage that follows its run request
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	initial begin
		link_clk_in = 1'b0;
		#7;
		forever #15 link_clk_in = ~link_clk_in;
	end
	always @(posedge ref_clk_in) stage_active_in <= stage_enable_out;
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic close_out;
		if (num_errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Feature_report, bad operation value, bit clear
	task automatic t_page0;
		u_host.wr(8'h00, 16'h0001, 1);
		u_host.wr(8'h01, 16'h0055, 1);
		u_host.wr(8'h00, 16'h0000, 1);
		u_host.rd(8'h19, v);
		chk(v & 16'h00ff, 16'h0020);
		u_host.rd(8'h7e, v);
		chk(v & 16'h0040, 16'h0040);
		u_host.wr(8'h7e, 16'h0040, 1);
		u_host.rd(8'h7e, v);
		chk(v & 16'h0040, 16'h0000);
	endtask
	// Turn off, limit writes, power-not-good
	task automatic t_limits;
		u_host.wr(8'h00, 16'h0001, 1);
		u_host.wr(8'h01, 16'h0000, 1);
		chk({15'h0, stage_enable_out}, 16'h0000);
		u_host.wr(8'h4f, 16'h0050, 2);
		u_host.rd(8'h4f, v);
		chk(v, 16'h0050);
		u_host.wr(8'h4f, 16'h0065, 2);
		u_host.rd(8'h4f, v);
		chk(v, 16'h0050);
		u_host.wr(8'h60, 16'h0003, 2);
		u_host.wr(8'h60, 16'h0065, 2);
		u_host.rd(8'h60, v);
		chk(v, 16'h0003);
		u_host.rd(8'h79, v);
		chk(v & 16'h0800, 16'h0800);
	endtask
	// Latched fault, clear, turn on, telemetry
	task automatic t_fault;
		@(posedge ref_clk_in) stage_evt_in.cur <= 8'h80;
		repeat (3) @(posedge ref_clk_in);
		stage_evt_in.cur <= 8'h00;
		u_host.rd(8'h7b, v);
		chk(v & 16'h0080, 16'h0080);
		u_host.wr(8'h03, 16'h0000, 0);
		u_host.rd(8'h7b, v);
		chk(v & 16'h0080, 16'h0000);
		u_host.wr(8'h01, 16'h0080, 1);
		repeat (80) @(posedge ref_clk_in);
		u_host.rd(8'h79, v);
		chk(v & 16'h0800, 16'h0000);
		@(posedge ref_clk_in);
		{telem_in.hi_v, telem_valid_in} <= {16'h0211, 1'b1};
		@(posedge ref_clk_in) telem_valid_in <= 1'b0;
		u_host.rd(8'h88, v);
		chk(v, 16'h0211);
		// Feature_report read is not allowed on page 1
		u_host.rd(8'h19, v);
		u_host.wr(8'h00, 16'h0000, 1);
		u_host.rd(8'h7e, v);
		chk(v & 16'h0080, 16'h0080);
	endtask
	initial begin
		{rst_in, hi_supply_ok_in, stage_talk_in, telem_valid_in} = 4'hc;
		{stage_evt_in, telem_in} = '0;
		repeat (16) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		repeat (6) @(posedge link_clk_in);
		t_page0;
		t_limits;
		t_fault;
		close_out;
	end
	// Watchdog
	initial begin
		#60000;
		num_errors++;
		close_out;
	end
endmodule
